// ---- hw/vec_prio_pkg.sv ----
package vec_prio_pkg;

  localparam int NSRC = 28;
  localparam int NPULSE = 24;

  typedef logic [1:0] level_t;
  typedef logic [4:0] src_idx_t;

  // Entry numbers in descending fixed order
  localparam src_idx_t SRC_RESET = 5'd0;
  localparam src_idx_t SRC_WDOG = 5'd1;
  localparam src_idx_t SRC_POSC_FAIL = 5'd2;
  localparam src_idx_t SRC_WOSC_FAIL = 5'd3;
  localparam src_idx_t SRC_ILLEGAL = 5'd4;
  localparam src_idx_t SRC_TIMER2 = 5'd5;
  localparam src_idx_t SRC_ADC = 5'd12;
  localparam src_idx_t SRC_PA7 = 5'd13;
  localparam src_idx_t SRC_PA6 = 5'd14;
  localparam src_idx_t SRC_PA5 = 5'd15;
  localparam src_idx_t SRC_PA4 = 5'd16;
  localparam src_idx_t SRC_PA0 = 5'd20;
  localparam src_idx_t SRC_PC3 = 5'd24;
  localparam src_idx_t SRC_PC0 = 5'd27;
  localparam int LAST_TRAP = 4;

  localparam level_t LVL_OFF = 2'h0;
  localparam level_t LVL_TOP = 2'h3;

  // Vector slot for each entry, same order as above
  localparam logic [15:0] VEC_SLOT [NSRC] = '{
    16'h0002, 16'h0004, 16'h003a, 16'h003c, 16'h0006,
    16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010,
    16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a,
    16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024,
    16'h0026, 16'h002a, 16'h002c, 16'h002e, 16'h0030,
    16'h0032, 16'h0034, 16'h0036};
  localparam logic [15:0] VEC_RSVD_A = 16'h0028;
  localparam logic [15:0] VEC_RSVD_B = 16'h0038;

  localparam logic [NSRC-1:0] PENDING_RST = '0;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef struct packed {
    logic [15:0] isr_addr;
    src_idx_t src;
  } vec_answer_t;

endpackage : vec_prio_pkg

// ---- hw/trap_interrupt_vector_prioritizer.sv ----
// Behaviour
// [RULE1] Vector high byte even, low byte odd
// [RULE2] Reset vectors 0002h, ranks first
// [RULE3] Watchdog vectors 0004h, second rank
// [RULE4] Oscillator fail traps 003Ah, 003Ch next
// [RULE5] Illegal instruction 0006h above peripherals
// [RULE6] Timers, UART0, I2C, SPI, ADC order
// [RULE7] Port A7 and low voltage share 0018h
// [RULE8] A6/comparator0 001Ah, A5/comparator1 001Ch
// [RULE9] Port A4..A1 share with D4..D1
// [RULE10] Port A0 alone at 0026h
// [RULE11] Port C3..C0 both edges, C0 last
// [RULE12] Fixed order only breaks level ties
// [RULE13] Absent sources never asserted
// [RULE14] Three levels, three highest
// [RULE15] Higher level always wins
// [RULE16] Traps and watchdog always level three; watchdog is forced off while watchdog_counter_int_en is low
// [RULE17] Sources pulse for one clock
// [RULE18] No reserved slot, single winner answered
`timescale 1ns/1ps
`default_nettype none
module trap_interrupt_vector_prioritizer
  import vec_prio_pkg::*;
#(
  parameter bit HAS_ADC = 1'b1,
  parameter logic [NSRC-1:0] PRESENT = '1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NPULSE-1:0] src_pulse,
  input wire logic low_voltage_detect_event,
  input wire logic cmp0_pulse,
  input wire logic cmp1_pulse,
  input wire logic [3:0] port_d_pulse,
  input wire logic [3:0] port_c_pin,
  input wire logic watchdog_counter_int_en,
  input wire level_t [NSRC-1:0] src_level,
  input wire logic vec_req,
  input wire logic [7:0] pm_data,
  output logic pm_rd,
  output logic [15:0] pm_addr,
  output logic irq_out,
  output logic vec_valid,
  output vec_answer_t answer
);

  typedef enum logic [1:0] {ST_IDLE, ST_HI, ST_LO, ST_DONE} fetch_st_t;

  // Port C edge detection, three stages for the pin crossing
  logic [3:0] pc_s1;
  logic [3:0] pc_s2;
  logic [3:0] pc_s3;
  logic [3:0] pc_stable;
  logic [3:0] next_pc_stable;
  logic [3:0] pc_edge;

  // [RULE11] Dual edge detect
  always_comb begin
    next_pc_stable = pc_stable;
    pc_edge = 4'h0;
    for (int b = 0; b < 4; b++) begin
      if (pc_s2[b] == pc_s3[b] && pc_s3[b] != pc_stable[b]) begin
        pc_edge[b] = 1'b1;
        next_pc_stable[b] = pc_s3[b];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_s1 <= 4'h0;
      pc_s2 <= 4'h0;
      pc_s3 <= 4'h0;
      pc_stable <= 4'h0;
    end else begin
      pc_s1 <= port_c_pin;
      pc_s2 <= pc_s1;
      pc_s3 <= pc_s2;
      pc_stable <= next_pc_stable;
    end
  end

  // Gather raw requests into the entry list
  logic [NSRC-1:0] raw_set;
  logic [NSRC-1:0] allowed;
  logic [NSRC-1:0] set;

  always_comb begin
    raw_set = '0;
    raw_set[NPULSE-1:0] = src_pulse;
    // [RULE7] Shared 0018h request
    raw_set[SRC_PA7] = src_pulse[SRC_PA7] | low_voltage_detect_event;
    // [RULE8] Comparator sharing
    raw_set[SRC_PA6] = src_pulse[SRC_PA6] | cmp0_pulse;
    raw_set[SRC_PA5] = src_pulse[SRC_PA5] | cmp1_pulse;
    // [RULE9] Port D merged with A
    for (int k = 0; k < 4; k++) begin
      raw_set[int'(SRC_PA4) + k] = src_pulse[int'(SRC_PA4) + k]
                                   | port_d_pulse[3 - k];
    end
    // [RULE11] C3 first, C0 last
    for (int k = 0; k < 4; k++) begin
      raw_set[int'(SRC_PC3) + k] = pc_edge[3 - k];
    end
    // [RULE13] Drop absent sources
    allowed = PRESENT;
    if (!HAS_ADC) begin
      allowed[SRC_ADC] = 1'b0;
    end
    // [RULE17] A one-cycle pulse sets pending once
    set = raw_set & allowed;
  end

  // Effective levels
  level_t [NSRC-1:0] eff_lvl;
  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] eligible;

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      eff_lvl[i] = src_level[i];
      // [RULE16] Traps pinned to top
      if (i <= LAST_TRAP) begin
        eff_lvl[i] = LVL_TOP;
      end
    end
    if (!watchdog_counter_int_en) begin
      eff_lvl[SRC_WDOG] = LVL_OFF;
    end
    for (int i = 0; i < NSRC; i++) begin
      eligible[i] = pending[i] && (eff_lvl[i] != LVL_OFF);
    end
  end

  // Resolution: strict compare keeps the earlier entry on a tie
  src_idx_t win_idx;
  level_t win_lvl;
  logic win_valid;
  logic [15:0] win_slot;
  logic [NSRC-1:0] lvl_ge_win;

  // [RULE12] Order is tie-break only
  // [RULE14] Levels 1 to 3
  // [RULE15] Higher level wins
  always_comb begin
    win_idx = SRC_RESET;
    win_lvl = LVL_OFF;
    win_valid = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (eligible[i] && eff_lvl[i] > win_lvl) begin
        win_idx = src_idx_t'(i);
        win_lvl = eff_lvl[i];
        win_valid = 1'b1;
      end
    end
    for (int i = 0; i < NSRC; i++) begin
      lvl_ge_win[i] = (eff_lvl[i] >= win_lvl);
    end
    // [RULE18] Table holds no reserved slot
    win_slot = VEC_SLOT[win_idx];
  end

  // Fetch sequencer
  fetch_st_t state;
  fetch_st_t next_state;
  logic [15:0] slot;
  logic [15:0] next_slot;
  logic [7:0] hi_byte;
  logic [7:0] next_hi_byte;
  logic [NSRC-1:0] next_pending;
  logic next_pm_rd;
  logic [15:0] next_pm_addr;
  logic next_irq_out;
  logic next_vec_valid;
  vec_answer_t next_answer;
  logic take;

  always_comb begin
    next_state = state;
    next_slot = slot;
    next_hi_byte = hi_byte;
    next_pm_rd = pm_rd;
    next_pm_addr = pm_addr;
    next_vec_valid = 1'b0;
    next_answer = answer;
    take = 1'b0;
    next_pending = pending;
    case (state)
      ST_IDLE: begin
        // Requests with nothing eligible are dropped
        if (vec_req && win_valid) begin
          take = 1'b1;
          next_slot = win_slot;
          next_answer.src = win_idx;
          next_pm_rd = 1'b1;
          // [RULE1] Even address first
          next_pm_addr = win_slot;
          next_state = ST_HI;
        end
      end
      ST_HI: begin
        next_pm_addr = slot | 16'h0001;
        next_state = ST_LO;
      end
      ST_LO: begin
        // [RULE1] High byte from even
        next_hi_byte = pm_data;
        next_pm_rd = 1'b0;
        next_state = ST_DONE;
      end
      ST_DONE: begin
        // [RULE1] Assemble high then low
        next_answer.isr_addr = {hi_byte, pm_data};
        next_vec_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Set applied after clear so a same-cycle event survives
    if (take) begin
      next_pending[win_idx] = 1'b0;
    end
    next_pending = next_pending | set;
    next_irq_out = |(next_pending & eligible_mask(eff_lvl));
  end

  function automatic logic [NSRC-1:0] eligible_mask(level_t [NSRC-1:0] l);
    logic [NSRC-1:0] m;
    m = '0;
    for (int i = 0; i < NSRC; i++) begin
      m[i] = (l[i] != LVL_OFF);
    end
    return m;
  endfunction : eligible_mask

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      slot <= ADDR_RST;
      hi_byte <= BYTE_RST;
      pending <= PENDING_RST;
      pm_rd <= 1'b0;
      pm_addr <= ADDR_RST;
      irq_out <= 1'b0;
      vec_valid <= 1'b0;
      answer <= '0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      hi_byte <= next_hi_byte;
      pending <= next_pending;
      pm_rd <= next_pm_rd;
      pm_addr <= next_pm_addr;
      irq_out <= next_irq_out;
      vec_valid <= next_vec_valid;
      answer <= next_answer;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    state == ST_IDLE && vec_req && win_valid;
  endsequence

  sequence s_fetch;
    pm_rd && !pm_addr[0] ##1 pm_rd && pm_addr[0] ##1 !pm_rd ##1 vec_valid;
  endsequence

  AST_FETCH_ORDER: assert property ( // [RULE1]
    s_take |=> s_fetch)
    else $error("vector fetch order wrong");

  AST_FETCH_ASSEMBLE: assert property ( // [RULE1]
    state == ST_DONE |=> answer.isr_addr == {$past(hi_byte), $past(pm_data)})
    else $error("vector bytes assembled wrongly");

  AST_RESET_FIRST: assert property ( // [RULE2]
    pending[SRC_RESET] |-> win_idx == SRC_RESET && win_slot == 16'h0002)
    else $error("reset did not win");

  AST_WDOG_SECOND: assert property ( // [RULE3]
    !pending[SRC_RESET] && eligible[SRC_WDOG]
      |-> win_idx == SRC_WDOG && win_slot == 16'h0004)
    else $error("watchdog not second");

  AST_OSC_TRAPS: assert property ( // [RULE4]
    eligible[SRC_POSC_FAIL] && eligible[2:0] == 3'b100
      |-> win_slot == 16'h003a)
    else $error("oscillator trap order wrong");

  AST_ILLEGAL: assert property ( // [RULE5]
    eligible[SRC_ILLEGAL] && eligible[3:0] == 4'h0 |-> win_slot == 16'h0006)
    else $error("illegal trap not ahead of peripherals");

  AST_TIMER2_SLOT: assert property ( // [RULE6]
    win_valid && win_idx == SRC_TIMER2 |-> win_slot == 16'h0008)
    else $error("timer 2 slot wrong");

  AST_LVD_SHARE: assert property ( // [RULE7]
    low_voltage_detect_event && allowed[SRC_PA7] |=> pending[SRC_PA7])
    else $error("low voltage event lost");

  AST_PC0_LAST: assert property ( // [RULE11]
    win_valid && win_idx == SRC_PC0
      |-> (eligible[NSRC-2:0] & lvl_ge_win[NSRC-2:0]) == '0)
    else $error("port C0 outranked another source");

  AST_LEVEL_WINS: assert property ( // [RULE15]
    win_valid && win_lvl != LVL_TOP |-> (eligible & eligible_top()) == '0)
    else $error("lower level beat level three");

  function automatic logic [NSRC-1:0] eligible_top();
    logic [NSRC-1:0] m;
    m = '0;
    for (int i = 0; i < NSRC; i++) begin
      m[i] = (eff_lvl[i] == LVL_TOP);
    end
    return m;
  endfunction : eligible_top

  AST_ADC_ABSENT: assert property ( // [RULE13]
    !allowed[SRC_ADC] |-> !pending[SRC_ADC])
    else $error("absent ADC source pending");

  AST_NO_RESERVED: assert property ( // [RULE18]
    s_take |=> slot != VEC_RSVD_A && slot != VEC_RSVD_B ##3 vec_valid)
    else $error("reserved slot selected");

endmodule : trap_interrupt_vector_prioritizer
`default_nettype wire

// ---- test/vec_fetch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vec_fetch_model (
  input wire logic sys_clk,
  input wire logic pm_rd,
  input wire logic [15:0] pm_addr,
  output logic [7:0] pm_data
);
  initial pm_data = 8'h00;
  // One byte per address
  // Bytes differ per address, so a swapped pair shows up.
  // Released bus inverts, so a late sample never matches by luck.
  always @(posedge sys_clk) begin
    if (pm_rd)
      pm_data <= pm_addr[7:0] ^ 8'ha5;
    else
      pm_data <= ~pm_data;
  end
endmodule : vec_fetch_model
`default_nettype wire

// ---- test/tb_trap_interrupt_vector_prioritizer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_trap_interrupt_vector_prioritizer;
  import vec_prio_pkg::*;
  logic sys_clk, rst, vec_req, low_voltage_detect_event;
  logic cmp0_pulse, cmp1_pulse, watchdog_counter_int_en;
  logic pm_rd, irq_out, vec_valid;
  logic [NPULSE-1:0] src_pulse;
  logic [3:0] port_d_pulse, port_c_pin;
  level_t [NSRC-1:0] src_level;
  logic [7:0] pm_data;
  logic [15:0] pm_addr;
  vec_answer_t answer;
  int failures, checked;

  trap_interrupt_vector_prioritizer i_dut (.sys_clk(sys_clk), .rst(rst),
    .src_pulse(src_pulse),
    .low_voltage_detect_event(low_voltage_detect_event),
    .cmp0_pulse(cmp0_pulse), .cmp1_pulse(cmp1_pulse),
    .port_d_pulse(port_d_pulse), .port_c_pin(port_c_pin),
    .watchdog_counter_int_en(watchdog_counter_int_en),
    .src_level(src_level), .vec_req(vec_req), .pm_data(pm_data),
    .pm_rd(pm_rd), .pm_addr(pm_addr), .irq_out(irq_out),
    .vec_valid(vec_valid), .answer(answer));
  vec_fetch_model i_mem (.sys_clk(sys_clk), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_data(pm_data));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] exp_vec(input int i);
    logic [15:0] t [5] = '{16'h0002, 16'h0004, 16'h003a, 16'h003c, 16'h0006};
    if (i < 5)
      return t[i];
    if (i < 21)
      return 16'h0008 + 16'(2 * (i - 5));
    return 16'h002a + 16'(2 * (i - 21));
  endfunction : exp_vec

  task automatic step;
    @(posedge sys_clk);
    #2;
  endtask : step

  task automatic final_report;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t vec got %h exp %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic chk_src(input src_idx_t got, input src_idx_t exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t src got %h exp %h", $time, got, exp);
    end
  endtask : chk_src

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t flag got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  // Ends in the vec_valid cycle, so the next request is back to back
  task automatic fetch(input int exp);
    logic [15:0] v;
    int n;
    v = exp_vec(exp);
    vec_req = 1'b1;
    step;
    vec_req = 1'b0;
    n = 0;
    while (vec_valid !== 1'b1 && n < 10) begin
      step;
      n++;
    end
    if (vec_valid !== 1'b1) begin
      failures++;
      final_report;
    end
    chk_src(answer.src, src_idx_t'(exp));
    chk_vec(answer.isr_addr,
      {v[7:0] ^ 8'ha5, (v[7:0] + 8'h01) ^ 8'ha5});
  endtask : fetch

  task automatic pulse(input logic [NPULSE-1:0] m);
    src_pulse = m;
    step;
    src_pulse = '0;
  endtask : pulse

  task automatic test_order;
    src_level = {NSRC{2'h2}};
    pulse('1);
    for (int i = 0; i < NPULSE; i++)
      fetch(i);
    step;
    chk_bit(irq_out, 1'b0);
    $display("test_order done");
  endtask : test_order

  task automatic test_levels;
    src_level = '0;
    src_level[5] = 2'h1;
    src_level[6] = 2'h2;
    src_level[7] = 2'h2;
    src_level[23] = 2'h3;
    pulse(24'h8000f0);
    fetch(4);
    fetch(23);
    fetch(6);
    fetch(7);
    fetch(5);
    $display("test_levels done");
  endtask : test_levels

  task automatic test_shared;
    src_level = {NSRC{2'h1}};
    low_voltage_detect_event = 1'b1;
    step;
    low_voltage_detect_event = 1'b0;
    fetch(13);
    cmp0_pulse = 1'b1;
    step;
    cmp0_pulse = 1'b0;
    fetch(14);
    cmp1_pulse = 1'b1;
    step;
    cmp1_pulse = 1'b0;
    fetch(15);
    for (int k = 3; k >= 0; k--) begin
      port_d_pulse = 4'h1 << k;
      step;
      port_d_pulse = '0;
      fetch(19 - k);
    end
    pulse(24'h100000);
    fetch(20);
    for (int k = 0; k < 4; k++) begin
      port_c_pin[k] = 1'b1;
      repeat (8) step;
      fetch(27 - k);
      port_c_pin[k] = 1'b0;
      repeat (8) step;
      fetch(27 - k);
    end
    $display("test_shared done");
  endtask : test_shared

  task automatic test_refuse;
    int seen;
    src_level = '0;
    watchdog_counter_int_en = 1'b0;
    pulse(24'h000022);
    step;
    chk_bit(irq_out, 1'b0);
    seen = 0;
    vec_req = 1'b1;
    repeat (8) begin
      step;
      seen += int'(vec_valid === 1'b1);
    end
    vec_req = 1'b0;
    chk_bit(seen != 0, 1'b0);
    watchdog_counter_int_en = 1'b1;
    step;
    chk_bit(irq_out, 1'b1);
    fetch(1);
    src_level[5] = 2'h1;
    fetch(5);
    $display("test_refuse done");
  endtask : test_refuse

  initial begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    vec_req = 1'b0;
    src_pulse = '0;
    low_voltage_detect_event = 1'b0;
    cmp0_pulse = 1'b0;
    cmp1_pulse = 1'b0;
    port_d_pulse = '0;
    port_c_pin = '0;
    src_level = '0;
    watchdog_counter_int_en = 1'b1;
    repeat (5) step;
    rst = 1'b0;
    test_order;
    test_levels;
    test_shared;
    test_refuse;
    final_report;
  end
endmodule : tb_trap_interrupt_vector_prioritizer
`default_nettype wire
